// file: inc/thermal_consts.vh
// Constants of the line thermal replica protection block
`ifndef THERMAL_CONSTS_VH
`define THERMAL_CONSTS_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_ALARM 8'h04
`define OFF_TRIP 8'h08
`define OFF_RATED 8'h0C
`define OFF_BASE 8'h10
`define OFF_UNLOCK 8'h14
`define OFF_AMBIENT 8'h18
`define OFF_STARTUP 8'h1C
`define OFF_INOM 8'h20
`define OFF_TAU 8'h24
`define OFF_TEMP 8'h28
`define OFF_STATUS 8'h2C
`define OFF_IRQ_STAT 8'h30
`define OFF_IRQ_MASK 8'h34
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_SENSOR_BIT 2
`define EV_ALARM 0
`define EV_TRIP 1
`define EV_LOCK 2
`define EV_STEP 3
// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define MODE_OFF 2'h0
`define MODE_PULSED 2'h1
`define MODE_LATCHED 2'h2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MODE 2'h1
`define RST_SENSOR 1'h0
`define RST_ALARM 8'h50
`define RST_TRIP 8'h64
`define RST_RATED 8'h64
`define RST_BASE 8'h19
`define RST_UNLOCK 8'h3C
`define RST_AMBIENT 8'h19
`define RST_STARTUP 8'h00
`define RST_INOM 8'h64
`define RST_TAU 10'h00A
`define RST_MASK 4'h0
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define STEP_US 1000
`define STEP_CYCLES_DEF (`CLK_HZ / 1000000 * `STEP_US)
`define MS_PER_MIN 16'hEA60
`define PCT_Q32 32'h028F_5C29
`endif

// file: src/line_thermal_replica_protection.v
// Line thermal replica overload protection with Wishbone register slave
// Operation
// RL1: Drive replica from largest phase RMS current
// RL2: Integrate heating equation, compare against thresholds
// RL3: Ambient input used only when sensor enabled
// RL4: Mode off, pulsed or latched; pulsed after reset
// RL5: Mode off keeps all status outputs low
// RL6: Pulsed mode pulses trip on rising crossing
// RL7: Latched trip holds until below unlock temperature
// RL8: Alarm output from alarm temperature setting
// RL9: General trip output from trip temperature setting
// RL10: Separate reclose lock status output
// RL11: Block input from user disables protection
// RL12: Heat reset loads defined starting temperature
// RL13: Status shows trip while above trip value; in pulsed mode the status trip bit is high for one cycle only
// RL14: Level steps toward squared current ratio
// RL15: Temperature is ambient plus computed rise
// RL16: Replica steps at one thousand per second
// RL17: Without sensor use ambient temperature setting
// RL18: Scale by rated current, temperature, time constant
// RL19: Computed temperature always readable
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "thermal_consts.vh"
module line_thermal_replica_protection #(
    parameter STEP_CYCLES = `STEP_CYCLES_DEF
) (
    input wire CLK_SYS, // System clock, 25 MHz
    input wire RSTN, // Asynchronous reset, active low
    input wire CE, // Clock enable, freezes all state when low
    input wire [7:0] ADR_I, // Wishbone byte address
    input wire [31:0] DAT_I, // Wishbone write data
    output reg [31:0] DAT_O, // Wishbone read data
    input wire WE_I, // Wishbone write enable
    input wire [3:0] SEL_I, // Wishbone byte lanes
    input wire STB_I, // Wishbone strobe
    input wire CYC_I, // Wishbone cycle
    output reg ACK_O, // Wishbone acknowledge
    input wire [15:0] PHASE1_RMS, // Phase 1 RMS current, percent
    input wire [15:0] PHASE2_RMS, // Phase 2 RMS current, percent
    input wire [15:0] PHASE3_RMS, // Phase 3 RMS current, percent
    input wire [7:0] AMBIENT_IN, // Sensor ambient temperature, deg
    input wire BLOCK_IN, // Disable protection
    input wire HEAT_RESET_IN, // Reset accumulated heat
    output reg ALARM_OUT, // Alarm status
    output reg GENERAL_TRIP_OUT, // General trip status
    output reg RECLOSE_LOCK_OUT, // Reclose blocking status
    output reg [15:0] COMPUTED_TEMP_VALUE, // Computed temperature, deg
    output reg IRQ // Interrupt, level
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_RATIO = 4'b0010;
    localparam [3:0] S_STEP = 4'b0100;
    localparam [3:0] S_APPLY = 4'b1000;
    localparam [31:0] STEP_END = STEP_CYCLES - 1;
    // Settings
    reg [1:0] mode_r;
    reg sensor_r;
    reg [7:0] alarm_set_r;
    reg [7:0] trip_set_r;
    reg [7:0] rated_r;
    reg [7:0] base_r;
    reg [7:0] unlock_r;
    reg [7:0] amb_set_r;
    reg [7:0] start_r;
    reg [7:0] inom_r;
    reg [9:0] tau_r;
    reg [3:0] irq_mask_r;
    reg [3:0] irq_stat_r;
    // Replica engine state
    reg [3:0] state_r;
    reg [15:0] step_cnt_r;
    reg [63:0] quo_r;
    reg [32:0] rem_r;
    reg [31:0] den_r;
    reg [5:0] bit_r;
    reg [47:0] h_r;
    reg [47:0] mag_r;
    reg up_r;
    reg hot_prev_r;
    // ------------------------------------------------------------
    // Maximum selection
    // ------------------------------------------------------------
    wire [15:0] max12 = (PHASE1_RMS > PHASE2_RMS) ? PHASE1_RMS : PHASE2_RMS; // RL1
    wire [15:0] imax = (max12 > PHASE3_RMS) ? max12 : PHASE3_RMS; // RL1
    wire [31:0] imax_sq = imax * imax;
    wire [15:0] inom_sq = inom_r * inom_r; // RL18
    wire [31:0] tau_ms = tau_r * `MS_PER_MIN; // RL18
    // ------------------------------------------------------------
    // Serial divider, one quotient bit per cycle
    // ------------------------------------------------------------
    wire [32:0] rem_sh = {rem_r[31:0], quo_r[63]};
    wire rem_ge = (rem_sh >= {1'b0, den_r});
    wire [32:0] rem_sub = rem_sh - {1'b0, den_r};
    wire [63:0] quo_fin = {quo_r[62:0], rem_ge};
    wire div_last = (bit_r == 6'h00);
    // Squared current ratio, saturated to the level width
    wire [47:0] target = (|quo_fin[63:48]) ? 48'hFFFF_FFFF_FFFF : quo_fin[47:0];
    // Level change for one step, never past the target
    wire [47:0] step_q = (|quo_fin[63:48] || quo_fin[47:0] > mag_r) ? mag_r : quo_fin[47:0];
    wire [39:0] h_start = start_r * `PCT_Q32; // RL12
    // ------------------------------------------------------------
    // Temperature from level
    // ------------------------------------------------------------
    wire [7:0] rise_n = (rated_r > base_r) ? (rated_r - base_r) : 8'h00; // RL18
    wire [39:0] rise_prod = h_r[47:16] * rise_n;
    wire [7:0] amb_use = sensor_r ? AMBIENT_IN : amb_set_r; // RL3 RL17
    wire [16:0] temp_sum = {1'b0, rise_prod[31:16]} + {9'h000, amb_use}; // RL15
    wire [15:0] temp_c = (|rise_prod[39:32] || temp_sum[16]) ? 16'hFFFF : temp_sum[15:0];
    // ------------------------------------------------------------
    // Protection decisions
    // ------------------------------------------------------------
    wire active = (mode_r == `MODE_PULSED || mode_r == `MODE_LATCHED) && !BLOCK_IN; // RL5 RL11
    wire hot = (temp_c > {8'h00, trip_set_r}); // RL2 RL13
    wire cool = (temp_c < {8'h00, unlock_r}); // RL7
    reg alarm_nxt;
    reg trip_nxt;
    reg lock_nxt;
    reg hot_prev_nxt;
    // Output next values, recomputed each step
    always @* begin
        alarm_nxt = ALARM_OUT;
        lock_nxt = RECLOSE_LOCK_OUT;
        hot_prev_nxt = hot_prev_r;
        trip_nxt = (mode_r == `MODE_LATCHED) ? GENERAL_TRIP_OUT : 1'b0;
        if (!active) begin
            alarm_nxt = 1'b0; // RL5
            lock_nxt = 1'b0; // RL5
            trip_nxt = 1'b0; // RL5
            hot_prev_nxt = 1'b0;
        end else if (state_r == S_APPLY) begin
            alarm_nxt = (temp_c > {8'h00, alarm_set_r}); // RL8
            hot_prev_nxt = hot;
            if (hot) begin
                lock_nxt = 1'b1; // RL10
            end else if (cool) begin
                lock_nxt = 1'b0; // RL10
            end
            if (mode_r == `MODE_LATCHED) begin
                trip_nxt = hot | (GENERAL_TRIP_OUT & !cool); // RL7 RL9
            end else begin
                trip_nxt = hot & !hot_prev_r; // RL6 RL9
            end
        end
    end
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire wb_go = CYC_I & STB_I & !ACK_O;
    wire wr_go = wb_go & WE_I;
    wire rd_clr = wb_go & !WE_I & (ADR_I == `OFF_IRQ_STAT);
    wire [3:0] events;
    assign events[`EV_ALARM] = alarm_nxt & !ALARM_OUT;
    assign events[`EV_TRIP] = trip_nxt & !GENERAL_TRIP_OUT;
    assign events[`EV_LOCK] = lock_nxt & !RECLOSE_LOCK_OUT;
    assign events[`EV_STEP] = (state_r == S_APPLY);
    // New events win over a clearing read
    wire [3:0] irq_stat_nxt = (rd_clr ? 4'h0 : irq_stat_r) | events;
    reg [31:0] rd_data;
    // Read multiplexer
    always @* begin
        rd_data = 32'h0000_0000;
        if (ADR_I == `OFF_CTRL) begin
            rd_data[2:0] = {sensor_r, mode_r};
        end else if (ADR_I == `OFF_ALARM) begin
            rd_data[7:0] = alarm_set_r;
        end else if (ADR_I == `OFF_TRIP) begin
            rd_data[7:0] = trip_set_r;
        end else if (ADR_I == `OFF_RATED) begin
            rd_data[7:0] = rated_r;
        end else if (ADR_I == `OFF_BASE) begin
            rd_data[7:0] = base_r;
        end else if (ADR_I == `OFF_UNLOCK) begin
            rd_data[7:0] = unlock_r;
        end else if (ADR_I == `OFF_AMBIENT) begin
            rd_data[7:0] = amb_set_r;
        end else if (ADR_I == `OFF_STARTUP) begin
            rd_data[7:0] = start_r;
        end else if (ADR_I == `OFF_INOM) begin
            rd_data[7:0] = inom_r;
        end else if (ADR_I == `OFF_TAU) begin
            rd_data[9:0] = tau_r;
        end else if (ADR_I == `OFF_TEMP) begin
            rd_data[15:0] = COMPUTED_TEMP_VALUE; // RL19
        end else if (ADR_I == `OFF_STATUS) begin
            rd_data[3:0] = {!state_r[0], RECLOSE_LOCK_OUT, GENERAL_TRIP_OUT, ALARM_OUT};
        end else if (ADR_I == `OFF_IRQ_STAT) begin
            rd_data[3:0] = irq_stat_r;
        end else if (ADR_I == `OFF_IRQ_MASK) begin
            rd_data[3:0] = irq_mask_r;
        end
    end
    // ------------------------------------------------------------
    // Wishbone slave and settings registers
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
            mode_r <= `RST_MODE; // RL4
            sensor_r <= `RST_SENSOR; // RL3
            alarm_set_r <= `RST_ALARM;
            trip_set_r <= `RST_TRIP;
            rated_r <= `RST_RATED;
            base_r <= `RST_BASE;
            unlock_r <= `RST_UNLOCK;
            amb_set_r <= `RST_AMBIENT;
            start_r <= `RST_STARTUP;
            inom_r <= `RST_INOM;
            tau_r <= `RST_TAU;
            irq_mask_r <= `RST_MASK;
            irq_stat_r <= 4'h0;
            IRQ <= 1'b0;
        end else if (CE) begin
            ACK_O <= wb_go;
            DAT_O <= (wb_go && !WE_I) ? rd_data : 32'h0000_0000;
            irq_stat_r <= irq_stat_nxt;
            IRQ <= |(irq_stat_nxt & irq_mask_r);
            if (wr_go && SEL_I[0]) begin
                if (ADR_I == `OFF_CTRL) begin
                    mode_r <= DAT_I[`CTRL_MODE_MSB:`CTRL_MODE_LSB]; // RL4
                    sensor_r <= DAT_I[`CTRL_SENSOR_BIT]; // RL3
                end else if (ADR_I == `OFF_ALARM) begin
                    alarm_set_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_TRIP) begin
                    trip_set_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_RATED) begin
                    rated_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_BASE) begin
                    base_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_UNLOCK) begin
                    unlock_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_AMBIENT) begin
                    amb_set_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_STARTUP) begin
                    start_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_INOM) begin
                    inom_r <= DAT_I[7:0];
                end else if (ADR_I == `OFF_TAU) begin
                    tau_r[7:0] <= DAT_I[7:0];
                end else if (ADR_I == `OFF_IRQ_MASK) begin
                    irq_mask_r <= DAT_I[3:0];
                end
            end
            if (wr_go && SEL_I[1] && ADR_I == `OFF_TAU) begin
                tau_r[9:8] <= DAT_I[9:8];
            end
        end
    end
    // ------------------------------------------------------------
    // Step timer and replica engine
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            step_cnt_r <= 16'h0000;
            state_r <= S_IDLE;
            quo_r <= 64'h0000_0000_0000_0000;
            rem_r <= 33'h0_0000_0000;
            den_r <= 32'h0000_0000;
            bit_r <= 6'h00;
            h_r <= 48'h0000_0000_0000;
            mag_r <= 48'h0000_0000_0000;
            up_r <= 1'b0;
        end else if (CE) begin
            // Fixed step rate, independent of the engine
            if (step_cnt_r == STEP_END[15:0]) begin
                step_cnt_r <= 16'h0000; // RL16
            end else begin
                step_cnt_r <= step_cnt_r + 16'h0001;
            end
            if (HEAT_RESET_IN) begin
                // Heat reset aborts any step in flight
                h_r <= {8'h00, h_start}; // RL12
                state_r <= S_APPLY;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (step_cnt_r == STEP_END[15:0]) begin
                            quo_r <= {imax_sq, 32'h0000_0000}; // RL14
                            rem_r <= 33'h0_0000_0000;
                            den_r <= {16'h0000, inom_sq}; // RL18
                            bit_r <= 6'h3F;
                            state_r <= S_RATIO;
                        end
                    end
                    S_RATIO: begin
                        rem_r <= rem_ge ? rem_sub : rem_sh;
                        quo_r <= quo_fin;
                        bit_r <= bit_r - 6'h01;
                        if (div_last) begin
                            up_r <= (target >= h_r);
                            mag_r <= (target >= h_r) ? (target - h_r) : (h_r - target);
                            quo_r <= {16'h0000, (target >= h_r) ? (target - h_r) : (h_r - target)};
                            rem_r <= 33'h0_0000_0000;
                            den_r <= tau_ms; // RL14 RL18
                            bit_r <= 6'h3F;
                            state_r <= S_STEP;
                        end
                    end
                    S_STEP: begin
                        rem_r <= rem_ge ? rem_sub : rem_sh;
                        quo_r <= quo_fin;
                        bit_r <= bit_r - 6'h01;
                        if (div_last) begin
                            h_r <= up_r ? (h_r + step_q) : (h_r - step_q); // RL2 RL14
                            state_r <= S_APPLY;
                        end
                    end
                    S_APPLY: begin
                        state_r <= S_IDLE;
                    end
                    default: begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // Status outputs and computed temperature
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ALARM_OUT <= 1'b0;
            GENERAL_TRIP_OUT <= 1'b0;
            RECLOSE_LOCK_OUT <= 1'b0;
            hot_prev_r <= 1'b0;
            COMPUTED_TEMP_VALUE <= 16'h0000;
        end else if (CE) begin
            ALARM_OUT <= alarm_nxt;
            GENERAL_TRIP_OUT <= trip_nxt;
            RECLOSE_LOCK_OUT <= lock_nxt;
            hot_prev_r <= hot_prev_nxt;
            if (state_r == S_APPLY) begin
                COMPUTED_TEMP_VALUE <= temp_c; // RL19
            end
        end
    end
endmodule // line_thermal_replica_protection

// file: dv/thermal_front_end.sv
// Model of the phase RMS front end and the user equation logic
`timescale 1ns/1ns

module thermal_front_end (
    input wire clk, // System clock
    output reg [15:0] ph1 = 16'h0000, // Phase 1 RMS, percent
    output reg [15:0] ph2 = 16'h0000, // Phase 2 RMS, percent
    output reg [15:0] ph3 = 16'h0000, // Phase 3 RMS, percent
    output reg [7:0] amb = 8'h00, // Sensor ambient, degrees
    output reg blk = 1'b0, // Protection block request
    output reg hrst = 1'b0 // Heat reset, test use only
);
    // New RMS values, held until the next call
    task set_rms(input [15:0] a, input [15:0] b, input [15:0] c);
        begin
            @(posedge clk);
            ph1 <= a;
            ph2 <= b;
            ph3 <= c;
        end
    endtask
    // Sensor ambient value, seen only with the sensor enabled
    task set_amb(input [7:0] v);
        begin
            @(posedge clk);
            amb <= v;
        end
    endtask
    // Block level from the user logic
    task set_blk(input v);
        begin
            @(posedge clk);
            blk <= v;
        end
    endtask
    // One-cycle heat reset request
    task heat_reset;
        begin
            @(posedge clk);
            hrst <= 1'b1;
            @(posedge clk);
            hrst <= 1'b0;
        end
    endtask
endmodule // thermal_front_end

// file: dv/line_thermal_replica_protection_properties.sv
// Port checker for the thermal replica protection block
`timescale 1ns/1ns
`include "thermal_consts.vh"

module line_thermal_replica_protection_properties (
    input wire CLK_SYS, // System clock
    input wire RSTN, // Reset, active low
    input wire [7:0] ADR_I, // Bus address
    input wire [31:0] DAT_I, // Bus write data
    input wire [31:0] DAT_O, // Bus read data
    input wire WE_I, // Bus write enable
    input wire [3:0] SEL_I, // Bus byte lanes
    input wire STB_I, // Bus strobe
    input wire CYC_I, // Bus cycle
    input wire ACK_O, // Bus acknowledge
    input wire BLOCK_IN, // Protection block
    input wire ALARM_OUT, // Alarm
    input wire GENERAL_TRIP_OUT, // General trip
    input wire RECLOSE_LOCK_OUT, // Reclose lock
    input wire [15:0] COMPUTED_TEMP_VALUE // Temperature
);
    reg [1:0] mode_r;
    reg [7:0] unlock_r;
    // Write taken at the same edge as in the slave, before its ack
    wire wr_take = CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];
    wire off = (mode_r == `MODE_OFF) || (mode_r == 2'h3);
    // Shadow of the mode and unlock settings
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mode_r <= `RST_MODE;
            unlock_r <= `RST_UNLOCK;
        end else if (wr_take && ADR_I == `OFF_CTRL) begin
            mode_r <= DAT_I[1:0];
        end else if (wr_take && ADR_I == `OFF_UNLOCK) begin
            unlock_r <= DAT_I[7:0];
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence s_quiet;
        !ALARM_OUT && !GENERAL_TRIP_OUT && !RECLOSE_LOCK_OUT;
    endsequence
    sequence s_trip_fall;
        $fell(GENERAL_TRIP_OUT) && mode_r == `MODE_LATCHED && !$past(BLOCK_IN);
    endsequence
    property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_answer; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not answered next cycle");
    property p_dat_idle; !ACK_O |-> DAT_O == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not zero outside ack");
    property p_off; off && $past(off) |-> s_quiet; endproperty
    a_off: assert property (p_off)
        else $error("status output high while off");
    property p_block; $past(BLOCK_IN) |-> s_quiet; endproperty
    a_block: assert property (p_block)
        else $error("status output high while blocked");
    property p_pulse;
        mode_r == `MODE_PULSED && $past(mode_r) == `MODE_PULSED && GENERAL_TRIP_OUT
            |=> !GENERAL_TRIP_OUT;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("pulsed trip longer than one cycle");
    property p_trip_lock; $rose(GENERAL_TRIP_OUT) |-> RECLOSE_LOCK_OUT; endproperty
    a_trip_lock: assert property (p_trip_lock)
        else $error("trip without reclose lock");
    property p_latched; s_trip_fall |-> COMPUTED_TEMP_VALUE < {8'h00, unlock_r}; endproperty
    a_latched: assert property (p_latched)
        else $error("latched trip fell above unlock");
    property p_temp_hold;
        !$stable(COMPUTED_TEMP_VALUE) |=> $stable(COMPUTED_TEMP_VALUE) [*8];
    endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("temperature updated faster than step");
endmodule // line_thermal_replica_protection_properties

bind line_thermal_replica_protection line_thermal_replica_protection_properties u_props (.*);

// file: dv/line_thermal_replica_protection_tb.sv
// Self-checking bench for the thermal replica protection block
`timescale 1ns/1ns
`include "thermal_consts.vh"

module line_thermal_replica_protection_tb;
    localparam SC = 500;
    localparam [55:0] RA = 56'h1C_2418_1408_0400;
    localparam [55:0] RV = 56'h00_0A19_3C64_5001;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] dat_i = 32'h0000_0000;
    reg [31:0] r;
    wire [31:0] dat_o;
    wire [15:0] p1, p2, p3, temp;
    wire [7:0] amb;
    wire ack, blk, hrst, alarm, trip, lock, irq;
    integer n_errors = 0;
    integer total_checks = 0;
    integer ntrip = 0;
    integer i;
    // Clock, 40 ns period
    initial begin
        forever #20 clk = ~clk;
    end
    line_thermal_replica_protection #(.STEP_CYCLES(SC)) dut (.CLK_SYS(clk), .RSTN(rstn),
        .CE(1'b1), .ADR_I(adr), .DAT_I(dat_i), .DAT_O(dat_o), .WE_I(we), .SEL_I(4'hF),
        .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .PHASE1_RMS(p1), .PHASE2_RMS(p2),
        .PHASE3_RMS(p3), .AMBIENT_IN(amb), .BLOCK_IN(blk), .HEAT_RESET_IN(hrst),
        .ALARM_OUT(alarm), .GENERAL_TRIP_OUT(trip), .RECLOSE_LOCK_OUT(lock),
        .COMPUTED_TEMP_VALUE(temp), .IRQ(irq));
    thermal_front_end fe (.clk(clk), .ph1(p1), .ph2(p2), .ph3(p3), .amb(amb), .blk(blk),
        .hrst(hrst));
    // Count cycles with the trip output high
    always @(posedge clk) begin
        if (trip === 1'b1) begin
            ntrip <= ntrip + 1;
        end
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    // Classic single bus cycle, result left in r
    task wb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat_i <= d;
            k = 0;
            @(posedge clk);
            while (ack !== 1'b1 && k < 20) begin
                @(posedge clk);
                k = k + 1;
            end
            if (ack !== 1'b1) begin
                n_errors = n_errors + 1;
                wrap_up;
            end
            r = dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        wb(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0000_0000);
            check(r, e);
        end
    endtask
    // Wait for n replica updates (apply state), then let the outputs settle
    task steps(input integer n);
        integer seen, k;
        begin
            seen = 0;
            k = 0;
            while (seen < n && k < n * SC + 400) begin
                @(posedge clk);
                k = k + 1;
                if (dut.state_r === 4'b1000) begin
                    seen = seen + 1;
                end
            end
            if (seen < n) begin
                n_errors = n_errors + 1;
                wrap_up;
            end
            repeat (2) @(posedge clk);
        end
    endtask
    task done(input [63:0] name);
        $display("test %0s done, errors %0d", name, n_errors);
    endtask
    task wrap_up;
        begin
            $display("checks %0d, mismatches %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            rd(RA[i*8 +: 8], {24'h0, RV[i*8 +: 8]});
        end
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 8'h00);
        steps(1);
        check(temp, 8'h19);
        done("reset");
        wr(`OFF_TAU, 8'h01);
        wr(`OFF_INOM, 8'h14);
        wr(`OFF_RATED, 8'hC8);
        wr(`OFF_BASE, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            fe.set_rms(i == 0 ? 16'h00C8 : 16'h0014, i == 1 ? 16'h00C8 : 16'h0014,
                i == 2 ? 16'h00C8 : 16'h0014);
            fe.heat_reset;
            steps(10);
            check(temp >= 16'h001B && temp <= 16'h001C, 1'b1);
        end
        done("maxsel");
        wr(`OFF_STARTUP, 8'h19);
        wr(`OFF_INOM, 8'h64);
        wr(`OFF_TAU, 8'h0A);
        wr(`OFF_TRIP, 8'h3C);
        wr(`OFF_ALARM, 8'h3C);
        wr(`OFF_UNLOCK, 8'h46);
        fe.set_rms(16'h000A, 16'h0032, 16'h001E);
        ntrip = 0;
        fe.heat_reset;
        steps(2);
        check(temp, 8'h4B);
        rd(`OFF_TEMP, 8'h4B);
        check(ntrip, 1);
        check({alarm, trip, lock, irq}, 4'hA);
        rd(`OFF_IRQ_STAT, 8'h0F);
        wb(1'b0, `OFF_IRQ_STAT, 0);
        check(r[2:0], 3'b000);
        wr(`OFF_IRQ_MASK, 8'h02);
        done("pulsed");
        wr(`OFF_CTRL, `MODE_LATCHED);
        steps(1);
        check({alarm, trip, lock, irq}, 4'hF);
        wb(1'b0, `OFF_STATUS, 0);
        check(r[2:0], 3'b111);
        wb(1'b0, `OFF_IRQ_STAT, 0);
        repeat (2) @(posedge clk);
        check({r[1], irq}, 2'b10);
        wr(`OFF_TRIP, 8'h5A);
        wr(`OFF_ALARM, 8'h50);
        steps(1);
        check({alarm, trip, lock}, 3'b011);
        fe.set_blk(1'b1);
        repeat (3) @(posedge clk);
        check({alarm, trip, lock}, 3'b000);
        fe.set_blk(1'b0);
        steps(1);
        check(trip, 1'b0);
        wr(`OFF_TRIP, 8'h3C);
        steps(1);
        check(trip, 1'b1);
        wr(`OFF_STARTUP, 8'h00);
        fe.set_rms(0, 0, 0);
        fe.heat_reset;
        steps(1);
        check({trip, lock, temp}, {2'b00, 16'h0019});
        done("latched");
        wr(`OFF_STARTUP, 8'h19);
        fe.set_rms(16'h0032, 16'h0032, 16'h0032);
        for (i = 0; i < 4; i = i + 3) begin
            wr(`OFF_CTRL, i[7:0]);
            fe.heat_reset;
            steps(2);
            check({alarm, trip, lock, temp}, {3'b000, 16'h004B});
        end
        wr(`OFF_CTRL, `MODE_PULSED);
        done("off");
        wr(`OFF_STARTUP, 8'h00);
        fe.set_rms(0, 0, 0);
        wr(`OFF_AMBIENT, 8'h0A);
        fe.set_amb(8'h28);
        fe.heat_reset;
        steps(1);
        check(temp, 8'h0A);
        wr(`OFF_CTRL, 8'h05);
        steps(1);
        check(temp, 8'h28);
        rd(`OFF_CTRL, 8'h05);
        done("sensor");
        wrap_up;
    end
endmodule // line_thermal_replica_protection_tb
